// file: logic/dpis_pkg.sv
// Purpose: Shared constants for the DDR power-up init sequencer (host side)
// Assumes: 20 MHz controller clock, the module clock runs at the same rate
// Notes:   Times kept in their own unit; cycle counts derived below
package dpis_pkg;
  // Clock
  localparam int CLK_PERIOD_NS = 50;
  localparam int CLK_PERIOD_PS = CLK_PERIOD_NS * 1000;
  // Power-up wait, least time, rounded up
  localparam int PWR_WAIT_NS   = 200000;
  localparam int PWR_WAIT_CYC  = (PWR_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Refresh spacing: average interval rounds down, longest gap rounds down
  localparam int REF_AVG_PS    = 7812500;
  localparam int REF_INT_CYC   = REF_AVG_PS / CLK_PERIOD_PS;
  localparam int REF_MAX_PS    = 70300000;
  localparam int REF_MAX_CYC   = REF_MAX_PS / CLK_PERIOD_PS;
  // Read lockout after a loop reset
  localparam int LOCK_CYC      = 200;
  // Default minimum times for the programmable waits
  localparam int BANK_CLOSE_NS = 15;
  localparam int MODE_LOAD_NS  = 10;
  localparam int REF_CYCLE_NS  = 70;
  localparam int RP_CYC        = (BANK_CLOSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MRD_CYC       = (MODE_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RFC_CYC       = (REF_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Widths
  localparam int TMR_W         = 12;
  localparam int LOCK_W        = 8;
  localparam int ADDR_W        = 13;
  localparam int CNT_W         = 16;
  // Commands as {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_LMR   = 4'h0;
  localparam logic [3:0] CMD_REF   = 4'h1;
  localparam logic [3:0] CMD_PRE   = 4'h2;
  localparam logic [3:0] CMD_NOP   = 4'h7;
  localparam logic [3:0] CMD_DESEL = 4'hf;
  localparam int CMD_CS_BIT        = 3;
  // Address and bank fields
  localparam int ALL_BANKS_BIT     = 10;
  localparam int DRIVE_BIT         = 1;
  localparam int LOOP_DISABLE_BIT  = 0;
  localparam int LOOP_RESET_BIT    = 8;
  localparam logic [1:0] BA_BASE   = 2'h0;
  localparam logic [1:0] BA_EXT    = 2'h1;
  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_MODE  = 8'h04;
  localparam logic [7:0] REG_TIM   = 8'h08;
  localparam logic [7:0] REG_STAT  = 8'h0c;
  localparam logic [7:0] REG_REFS  = 8'h10;
  // Control fields
  localparam int CTRL_START  = 0;
  localparam int CTRL_DRIVE  = 1;
  localparam int CTRL_CLEAR  = 2;
  localparam int CTRL_RELOCK = 3;
  // Timing fields
  localparam int TIM_RP_LSB  = 0;
  localparam int TIM_MRD_LSB = 4;
  localparam int TIM_RFC_LSB = 8;
  localparam logic [31:0] TIM_RST  = 32'(RFC_CYC << TIM_RFC_LSB) | 32'(MRD_CYC << TIM_MRD_LSB) | 32'(RP_CYC);
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  // Status fields
  localparam int STAT_DONE   = 0;
  localparam int STAT_READOK = 1;
  localparam int STAT_REFBSY = 2;
  localparam int STAT_ST_LSB = 8;

  typedef enum logic [4:0] {
    ST_IDLE, ST_PWR_WAIT, ST_CKE_NOP, ST_PRE1, ST_RP1, ST_EMR, ST_MRD1, ST_MR, ST_MRD2,
    ST_PRE2, ST_RP2, ST_REF1, ST_RFC1, ST_REF2, ST_RFC2, ST_MRCLR, ST_MRD3,
    ST_READY, ST_REFRUN, ST_RFCRUN, ST_RELOCK, ST_MRD4
  } dpis_state_e;
endpackage

// file: logic/dpis_tmr_if.sv
// Purpose: Carrier between the sequencer and its wait timer
// Assumes: Single clock domain
// Notes:   Load wins over counting
`timescale 1ns/1ps
interface dpis_tmr_if;
  logic                       load;    // Load request
  logic [dpis_pkg::TMR_W-1:0] loadVal; // Cycles to wait
  logic                       zero;    // Wait elapsed
  modport ctl (output load, output loadVal, input zero);
  modport tmr (input load, input loadVal, output zero);
endinterface

// file: logic/dpis_timer.sv
// Purpose: Down counter for all timed waits of the sequencer
// Assumes: Loaded on the command cycle, counted every clock
// Notes:   Holds at zero until loaded again
`timescale 1ns/1ps
module dpis_timer (
  input wire logic clk,  // 20 MHz clock
  input wire logic srst, // Synchronous reset
  dpis_tmr_if.tmr  t     // Load and done
);
  logic [dpis_pkg::TMR_W-1:0] cnt_r;
  logic [dpis_pkg::TMR_W-1:0] cnt_nxt;

  // Load first, else step down to zero
  assign cnt_nxt = t.load ? t.loadVal : (cnt_r == '0 ? cnt_r : cnt_r - 1'b1);
  assign t.zero  = (cnt_r == '0); // Read only in wait states, so no loop through load

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// file: logic/dpis_top.sv
// Purpose: Host-side power-up init and refresh sequencer for a registered DDR module
// Assumes: Module clock equals clk; software talks over classic Wishbone
// Notes:   Command pins are registered; power wait and lockout are conservative by one cycle, command waits by two
// Contract
// - Keep clock-enable low after power-up while the clock stabilises.
// - Wait at least 200us with clock-enable low before commands.
// - Raise clock-enable and give a no-operation before any other command.
// - Issue close-all-banks, then wait the bank-close time.
// - Only no-operation or idle-unselected commands during timed waits.
// - Load extended mode: loop enabled, drive bit chosen, higher bits zero.
// - Wait the mode-load time after every mode load.
// - Load base mode with loop reset; 200 cycles before any read.
// - Second close-all-banks after base mode load, then bank-close wait.
// - Two row refreshes, each followed by the refresh cycle time.
// - Optional mode load clearing loop reset, same operating parameters.
// - Clock-enable high on every edge during a refresh period.
// - After a clock frequency change, reset the loop, 200 cycles before reads.
// - Refresh every 7.8125us on average, never a gap over 70.3us.
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
module dpis_top (
  input  wire logic        clk,      // 20 MHz clock
  input  wire logic        srst,     // Synchronous reset, active high
  input  wire logic        wbCyc,    // Wishbone cycle
  input  wire logic        wbStb,    // Wishbone strobe
  input  wire logic        wbWe,     // Wishbone write
  input  wire logic [7:0]  wbAdr,    // Byte address
  input  wire logic [3:0]  wbSel,    // Byte lanes
  input  wire logic [31:0] wbDatI,   // Write data
  output logic      [31:0] wbDatO,   // Read data
  output logic             wbAck,    // Acknowledge
  output logic             ddrCke,   // Clock enable
  output logic             ddrCsN,   // Chip select, low active
  output logic             ddrRasN,  // Row strobe, low active
  output logic             ddrCasN,  // Column strobe, low active
  output logic             ddrWeN,   // Write enable, low active
  output logic      [1:0]  ddrBa,    // Bank address
  output logic      [12:0] ddrAddr,  // Address
  output logic             initDone, // Init finished
  output logic             readOk    // Reads allowed
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  dpis_pkg::dpis_state_e state_r, stateNxt;
  logic [3:0]  cmd_r, cmdNxt;
  logic [1:0]  ba_r, baNxt;
  logic [12:0] addr_r, addrNxt;
  logic        cke_r, ckeNxt;
  logic        ack_r, done_r, readOk_r;
  logic [31:0] datO_r, rdMux;
  logic [31:0] ctrl_r, mode_r, tim_r;
  logic        startPend_r, relockPend_r, refPend_r;
  logic [dpis_pkg::LOCK_W-1:0] lockCnt_r;
  logic [dpis_pkg::TMR_W-1:0]  refCnt_r;
  logic [dpis_pkg::CNT_W-1:0]  refs_r;
  logic        lockLoad, wrHit, rdHit, refTick;
  logic [3:0]  rpCyc, mrdCyc;
  logic [7:0]  rfcCyc;
  logic [12:0] modeWord;
  dpis_tmr_if  tmr ();

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Byte-lane merge for writable registers
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (wd & m);
  endfunction
  // Command that is neither no-operation nor idle-unselected
  function automatic logic busyCmd(input logic [3:0] c);
    return !c[dpis_pkg::CMD_CS_BIT] && (c != dpis_pkg::CMD_NOP);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after request, write at the acked edge
  assign wrHit = wbCyc && wbStb && wbWe && ack_r;
  assign rdHit = wbCyc && wbStb && !ack_r;
  assign rdMux = (wbAdr == dpis_pkg::REG_CTRL) ? {29'h0000_0000, ctrl_r[dpis_pkg::CTRL_CLEAR],
                                                   ctrl_r[dpis_pkg::CTRL_DRIVE], 1'b0} :
                 (wbAdr == dpis_pkg::REG_MODE) ? {19'h0_0000, mode_r[12:0]} :
                 (wbAdr == dpis_pkg::REG_TIM)  ? {16'h0000, tim_r[15:0]} :
                 (wbAdr == dpis_pkg::REG_STAT) ? {19'h0_0000, state_r, 5'h00, refPend_r, readOk_r, done_r} :
                 (wbAdr == dpis_pkg::REG_REFS) ? {16'h0000, refs_r} : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_r  <= 1'b0;
      datO_r <= 32'h0000_0000;
    end else begin
      ack_r  <= wbCyc && wbStb && !ack_r;
      datO_r <= rdHit ? rdMux : datO_r;
    end
  end

  // Software registers; control pulses become pending flags
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_r <= 32'h0000_0000;
      mode_r <= dpis_pkg::MODE_RST;
      tim_r  <= dpis_pkg::TIM_RST;
    end else if (wrHit) begin
      ctrl_r <= (wbAdr == dpis_pkg::REG_CTRL) ? laneMerge(ctrl_r, wbDatI, wbSel) : ctrl_r;
      mode_r <= (wbAdr == dpis_pkg::REG_MODE) ? laneMerge(mode_r, wbDatI, wbSel) : mode_r;
      tim_r  <= (wbAdr == dpis_pkg::REG_TIM) ? laneMerge(tim_r, wbDatI, wbSel) : tim_r;
    end
  end

  // Start and relock requests; a new request wins over consumption
  always_ff @(posedge clk) begin
    if (srst) begin
      startPend_r  <= 1'b0;
      relockPend_r <= 1'b0;
    end else begin
      startPend_r  <= (wrHit && wbAdr == dpis_pkg::REG_CTRL && wbSel[0] && wbDatI[dpis_pkg::CTRL_START])
                      || (startPend_r && state_r != dpis_pkg::ST_IDLE);
      relockPend_r <= (wrHit && wbAdr == dpis_pkg::REG_CTRL && wbSel[0] && wbDatI[dpis_pkg::CTRL_RELOCK])
                      || (relockPend_r && state_r != dpis_pkg::ST_RELOCK);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  assign rpCyc    = tim_r[dpis_pkg::TIM_RP_LSB +: 4];
  assign mrdCyc   = tim_r[dpis_pkg::TIM_MRD_LSB +: 4];
  assign rfcCyc   = tim_r[dpis_pkg::TIM_RFC_LSB +: 8];
  assign modeWord = mode_r[12:0];
  // Clock-enable stays low until the power wait is over, high ever after
  assign ckeNxt   = !(stateNxt inside {dpis_pkg::ST_IDLE, dpis_pkg::ST_PWR_WAIT});

  // Next state and command; the power wait emits idle-unselected, other wait states only no-operation
  always_comb begin
    stateNxt    = state_r;
    cmdNxt      = dpis_pkg::CMD_NOP;
    baNxt       = dpis_pkg::BA_BASE;
    addrNxt     = '0;
    tmr.load    = 1'b0;
    tmr.loadVal = '0;
    lockLoad    = 1'b0;
    unique case (state_r)
      dpis_pkg::ST_IDLE: begin
        cmdNxt = dpis_pkg::CMD_DESEL;
        if (startPend_r) begin
          stateNxt    = dpis_pkg::ST_PWR_WAIT;
          tmr.load    = 1'b1;
          tmr.loadVal = dpis_pkg::TMR_W'(dpis_pkg::PWR_WAIT_CYC);
        end
      end
      dpis_pkg::ST_PWR_WAIT: begin
        cmdNxt = dpis_pkg::CMD_DESEL;
        if (tmr.zero) stateNxt = dpis_pkg::ST_CKE_NOP;
      end
      dpis_pkg::ST_CKE_NOP: stateNxt = dpis_pkg::ST_PRE1;
      dpis_pkg::ST_PRE1, dpis_pkg::ST_PRE2: begin
        cmdNxt                 = dpis_pkg::CMD_PRE;
        addrNxt[dpis_pkg::ALL_BANKS_BIT] = 1'b1;
        tmr.load               = 1'b1;
        tmr.loadVal            = dpis_pkg::TMR_W'(rpCyc);
        stateNxt = (state_r == dpis_pkg::ST_PRE1) ? dpis_pkg::ST_RP1 : dpis_pkg::ST_RP2;
      end
      dpis_pkg::ST_RP1: if (tmr.zero) stateNxt = dpis_pkg::ST_EMR;
      dpis_pkg::ST_EMR: begin
        cmdNxt      = dpis_pkg::CMD_LMR;
        baNxt       = dpis_pkg::BA_EXT;
        addrNxt[dpis_pkg::LOOP_DISABLE_BIT] = 1'b0;
        addrNxt[dpis_pkg::DRIVE_BIT]        = ctrl_r[dpis_pkg::CTRL_DRIVE];
        tmr.load    = 1'b1;
        tmr.loadVal = dpis_pkg::TMR_W'(mrdCyc);
        stateNxt    = dpis_pkg::ST_MRD1;
      end
      dpis_pkg::ST_MRD1: if (tmr.zero) stateNxt = dpis_pkg::ST_MR;
      dpis_pkg::ST_MR, dpis_pkg::ST_RELOCK: begin
        cmdNxt      = dpis_pkg::CMD_LMR;
        addrNxt     = modeWord;
        addrNxt[dpis_pkg::LOOP_RESET_BIT] = 1'b1;
        lockLoad    = 1'b1;
        tmr.load    = 1'b1;
        tmr.loadVal = dpis_pkg::TMR_W'(mrdCyc);
        stateNxt = (state_r == dpis_pkg::ST_MR) ? dpis_pkg::ST_MRD2 : dpis_pkg::ST_MRD4;
      end
      dpis_pkg::ST_MRD2: if (tmr.zero) stateNxt = dpis_pkg::ST_PRE2;
      dpis_pkg::ST_RP2:  if (tmr.zero) stateNxt = dpis_pkg::ST_REF1;
      dpis_pkg::ST_REF1, dpis_pkg::ST_REF2, dpis_pkg::ST_REFRUN: begin
        cmdNxt      = dpis_pkg::CMD_REF;
        tmr.load    = 1'b1;
        tmr.loadVal = dpis_pkg::TMR_W'(rfcCyc);
        stateNxt = (state_r == dpis_pkg::ST_REF1) ? dpis_pkg::ST_RFC1 :
                   (state_r == dpis_pkg::ST_REF2) ? dpis_pkg::ST_RFC2 : dpis_pkg::ST_RFCRUN;
      end
      dpis_pkg::ST_RFC1: if (tmr.zero) stateNxt = dpis_pkg::ST_REF2;
      dpis_pkg::ST_RFC2: begin
        if (tmr.zero) begin
          stateNxt = ctrl_r[dpis_pkg::CTRL_CLEAR] ? dpis_pkg::ST_MRCLR : dpis_pkg::ST_READY;
        end
      end
      dpis_pkg::ST_MRCLR: begin
        cmdNxt      = dpis_pkg::CMD_LMR;
        addrNxt     = modeWord;
        addrNxt[dpis_pkg::LOOP_RESET_BIT] = 1'b0;
        tmr.load    = 1'b1;
        tmr.loadVal = dpis_pkg::TMR_W'(mrdCyc);
        stateNxt    = dpis_pkg::ST_MRD3;
      end
      dpis_pkg::ST_MRD3, dpis_pkg::ST_MRD4: if (tmr.zero) stateNxt = dpis_pkg::ST_READY;
      dpis_pkg::ST_RFCRUN: if (tmr.zero) stateNxt = dpis_pkg::ST_READY;
      dpis_pkg::ST_READY: begin
        // Refresh first: a relock must not push the refresh gap out
        if (refPend_r) stateNxt = dpis_pkg::ST_REFRUN;
        else if (relockPend_r) stateNxt = dpis_pkg::ST_RELOCK;
      end
      default: stateNxt = dpis_pkg::ST_IDLE;
    endcase
  end

  dpis_timer u_timer (
    .clk  (clk),
    .srst (srst),
    .t    (tmr.tmr)
  );

  // State and registered pins
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= dpis_pkg::ST_IDLE;
      cmd_r   <= dpis_pkg::CMD_DESEL;
      ba_r    <= 2'h0;
      addr_r  <= 13'h0000;
      cke_r   <= 1'b0;
    end else begin
      state_r <= stateNxt;
      cmd_r   <= cmdNxt;
      ba_r    <= baNxt;
      addr_r  <= addrNxt;
      cke_r   <= ckeNxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lockout, completion and periodic refresh
  assign refTick = done_r && (refCnt_r == '0);

  always_ff @(posedge clk) begin
    if (srst) begin
      lockCnt_r <= '0;
      done_r    <= 1'b0;
      readOk_r  <= 1'b0;
      refCnt_r  <= '0;
      refPend_r <= 1'b0;
      refs_r    <= '0;
    end else begin
      lockCnt_r <= lockLoad ? dpis_pkg::LOCK_W'(dpis_pkg::LOCK_CYC) :
                   (lockCnt_r == '0 ? lockCnt_r : lockCnt_r - 1'b1);
      done_r    <= (state_r == dpis_pkg::ST_READY) || (done_r && state_r != dpis_pkg::ST_IDLE);
      readOk_r  <= done_r && (lockCnt_r == '0) && !lockLoad;
      refCnt_r  <= (!done_r || refTick) ? dpis_pkg::TMR_W'(dpis_pkg::REF_INT_CYC - 1) : refCnt_r - 1'b1;
      refPend_r <= refTick || (refPend_r && state_r != dpis_pkg::ST_REFRUN);
      refs_r    <= refs_r + dpis_pkg::CNT_W'(cmd_r == dpis_pkg::CMD_REF);
    end
  end

  assign wbDatO   = datO_r;
  assign wbAck    = ack_r;
  assign ddrCke   = cke_r;
  assign {ddrCsN, ddrRasN, ddrCasN, ddrWeN} = cmd_r;
  assign ddrBa    = ba_r;
  assign ddrAddr  = addr_r;
  assign initDone = done_r;
  assign readOk   = readOk_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks and their helper counters
  logic [12:0] lowCnt_r;
  logic [11:0] sinceCmd_r, sinceRef_r;
  logic [3:0]  lastCmd_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      lowCnt_r   <= '0;
      sinceCmd_r <= '0;
      sinceRef_r <= '0;
      lastCmd_r  <= dpis_pkg::CMD_NOP;
    end else begin
      lowCnt_r   <= (cke_r || state_r == dpis_pkg::ST_IDLE) ? '0 : lowCnt_r + 1'b1;
      sinceCmd_r <= busyCmd(cmd_r) ? 12'h001 : sinceCmd_r + 1'b1;
      lastCmd_r  <= busyCmd(cmd_r) ? cmd_r : lastCmd_r;
      sinceRef_r <= (cmd_r == dpis_pkg::CMD_REF) ? '0 : sinceRef_r + 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_loop_reset;
    cmd_r == dpis_pkg::CMD_LMR && ba_r == dpis_pkg::BA_BASE && addr_r[dpis_pkg::LOOP_RESET_BIT];
  endsequence
  sequence s_refresh;
    cmd_r == dpis_pkg::CMD_REF;
  endsequence

  a_cke_power_wait: assert property ($rose(cke_r) |-> lowCnt_r >= dpis_pkg::PWR_WAIT_CYC)
    else $error("clock-enable rose before the power-up wait");
  a_first_cmd_nop: assert property ($rose(cke_r) |-> cmd_r == dpis_pkg::CMD_DESEL ##1 cmd_r == dpis_pkg::CMD_NOP
                                    ##1 cmd_r == dpis_pkg::CMD_PRE)
    else $error("first command after clock-enable is not a no-operation");
  a_cke_low_idle: assert property (!cke_r |-> cmd_r == dpis_pkg::CMD_DESEL)
    else $error("command issued while clock-enable low");
  a_bank_close_gap: assert property (busyCmd(cmd_r) && lastCmd_r == dpis_pkg::CMD_PRE
                                     |-> sinceCmd_r > 12'(rpCyc))
    else $error("bank-close time violated");
  a_ext_mode_bits: assert property (cmd_r == dpis_pkg::CMD_LMR && ba_r == dpis_pkg::BA_EXT
                                    |-> addr_r[12:2] == '0 && !addr_r[dpis_pkg::LOOP_DISABLE_BIT])
    else $error("extended mode load has illegal bits");
  a_mode_load_gap: assert property (busyCmd(cmd_r) && lastCmd_r == dpis_pkg::CMD_LMR
                                    |-> sinceCmd_r > 12'(mrdCyc))
    else $error("mode-load time violated");
  a_refresh_gap: assert property (busyCmd(cmd_r) && lastCmd_r == dpis_pkg::CMD_REF
                                  |-> sinceCmd_r > 12'(rfcCyc))
    else $error("refresh cycle time violated");
  a_read_lockout: assert property (s_loop_reset |-> !readOk_r [*8])
    else $error("reads allowed too soon after loop reset");
  a_cke_refresh: assert property (s_refresh |-> cke_r ##1 cke_r)
    else $error("clock-enable low during refresh");
  a_refresh_max: assert property (done_r |-> sinceRef_r < 12'(dpis_pkg::REF_MAX_CYC))
    else $error("refresh gap too long");
  a_done_ready: assert property ($rose(done_r) |-> $past(state_r) == dpis_pkg::ST_READY && refs_r >= 2)
    else $error("done raised before init finished");
endmodule

// file: sim/dpis_ddr_model.sv
// Purpose: Behavioural memory module seen from its command pins
// Assumes: Device clock equals clk; expected counts come from the bench
// Notes:   Counts protocol faults instead of stopping, so the bench can compare
`timescale 1ns/1ps
module dpis_ddr_model (
  input wire logic        clk,     // Clock
  input wire logic        srst,    // Sync reset
  input wire logic        ddrCke,  // Clock enable
  input wire logic        ddrCsN,  // Chip select
  input wire logic        ddrRasN, // Row strobe
  input wire logic        ddrCasN, // Column strobe
  input wire logic        ddrWeN,  // Write enable
  input wire logic [1:0]  ddrBa,   // Bank
  input wire logic [12:0] ddrAddr, // Address
  input wire logic [12:0] modeVal, // Expected parameters
  input wire logic        drive,   // Expected drive bit
  input wire logic        clrEn,   // Final clear expected
  input wire logic [3:0]  rpCyc,   // Bank-close count
  input wire logic [3:0]  mrdCyc,  // Mode-load count
  input wire logic [7:0]  rfcCyc,  // Refresh-cycle count
  output int              errCnt,  // Faults seen
  output int              stepCnt, // Init commands taken
  output int              refCnt,  // Refreshes taken
  output int              lockAge  // Cycles since loop reset
);
  logic [3:0] cmd;
  logic       idle;
  logic       ckeUp;
  logic       good;
  int         lowCyc, gap, need, refGap, dn;
  // Command decode
  assign cmd  = {ddrCsN, ddrRasN, ddrCasN, ddrWeN};
  assign idle = (cmd == dpis_pkg::CMD_NOP) || (cmd == dpis_pkg::CMD_DESEL);
  ////////////////////////////////////////////////////////////
  // Blocking tracker, so the bench reads it at the falling edge
  always @(posedge clk) begin
    dn = clrEn ? 7 : 6;
    if (srst) begin
      {errCnt, stepCnt, refCnt, lockAge, lowCyc, gap, need, refGap} = '0;
      ckeUp = 1'b0;
    end else begin
      lockAge++;
      gap++;
      refGap++;
      if (!ckeUp) begin
        lowCyc += !ddrCke;
        if (idle !== 1'b1) errCnt++;
        if (ddrCke === 1'b1) begin
          ckeUp = 1'b1;
          if (lowCyc < dpis_pkg::PWR_WAIT_CYC) errCnt++;
        end
      end else begin
        if (ddrCke !== 1'b1) errCnt++;
        if (stepCnt >= dn && refGap > dpis_pkg::REF_MAX_CYC) errCnt++;
        if (!idle) begin
          if (gap < need) errCnt++;
          gap  = 0;
          good = 1'b0;
          case (cmd)
            dpis_pkg::CMD_PRE: begin
              good = ddrAddr[dpis_pkg::ALL_BANKS_BIT] && (stepCnt == 0 || stepCnt == 3);
              need = rpCyc + 1;
            end
            dpis_pkg::CMD_REF: begin
              good   = stepCnt == 4 || stepCnt == 5 || stepCnt >= dn;
              need   = rfcCyc + 1;
              refGap = 0;
              refCnt++;
            end
            dpis_pkg::CMD_LMR: begin
              need = mrdCyc + 1;
              if (stepCnt == 1) good = ddrBa == dpis_pkg::BA_EXT && ddrAddr == {11'h000, drive, 1'b0};
              else good = ddrBa == dpis_pkg::BA_BASE && ddrAddr[12:9] == modeVal[12:9]
                && ddrAddr[7:0] == modeVal[7:0]
                && (stepCnt == 2 ? ddrAddr[8] : (stepCnt == 6 && clrEn) ? !ddrAddr[8] : stepCnt >= 6);
              if (good && ddrAddr[8]) lockAge = 0;
            end
            default: good = 1'b0;
          endcase
          if (!good) errCnt++;
          if (stepCnt < dn) stepCnt++;
        end
      end
    end
  end
endmodule

// file: sim/tb.sv
// Purpose: Self-checking bench for the power-up init sequencer
// Assumes: Device clock equals clk; register map as handed over
// Notes:   Run 0 keeps default waits, run 1 draws them and adds the final clear
`timescale 1ns/1ps
module tb;
  logic        clk = 0, srst = 1, wbCyc = 0, wbStb = 0, wbWe = 0, drive = 1, clrEn = 0;
  logic [7:0]  wbAdr = '0;
  logic [3:0]  wbSel = '0, rpCyc = 1, mrdCyc = 1;
  logic [7:0]  rfcCyc = 2;
  logic [12:0] modeVal = '0;
  logic [31:0] wbDatI = '0, rd, rnd = 32'h3ea0_01c9;
  logic [31:0] wbDatO;
  logic        wbAck, ddrCke, ddrCsN, ddrRasN, ddrCasN, ddrWeN, initDone, readOk;
  logic [1:0]  ddrBa;
  logic [12:0] ddrAddr;
  int          errTotal = 0, samplesChecked = 0, errCnt, stepCnt, refCnt, lockAge, r0;
  // Clock and instances
  always #25 clk = ~clk;
  dpis_top DUT (.clk, .srst, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatI, .wbDatO, .wbAck, .ddrCke, .ddrCsN,
                .ddrRasN, .ddrCasN, .ddrWeN, .ddrBa, .ddrAddr, .initDone, .readOk);
  dpis_ddr_model mdl (.clk, .srst, .ddrCke, .ddrCsN, .ddrRasN, .ddrCasN, .ddrWeN, .ddrBa, .ddrAddr, .modeVal,
                      .drive, .clrEn, .rpCyc, .mrdCyc, .rfcCyc, .errCnt, .stepCnt, .refCnt, .lockAge);
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Classic single cycle; request held until ack is sampled, then a gap
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= adr;
    wbSel  <= 4'hf;
    wbDatI <= dat;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
    chk("wishbone ack", n, 2);
  endtask
  // Bounded wait on a status level
  task automatic waitSig(input bit useReady, input logic lvl, input int lim, input string name);
    int n;
    n = 0;
    while ((useReady ? readOk : initDone) !== lvl && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(name, 32'(n < lim), 1);
  endtask
  task automatic results;
    $display("Checks %0d, mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog, about four times the expected run
  initial begin
    repeat (40000) @(posedge clk);
    errTotal++;
    results();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    for (int run = 0; run < 2; run++) begin
      if (run == 1) begin
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
      end
      @(posedge clk);
      chk("cke low", 32'(ddrCke), 0);
      chk("idle cmd", 32'({ddrCsN, ddrRasN, ddrCasN, ddrWeN}), 32'(dpis_pkg::CMD_DESEL));
      chk("flags", 32'({readOk, initDone}), 0);
      wb(1'b0, dpis_pkg::REG_TIM, 0);
      chk("timing reset", rd, dpis_pkg::TIM_RST);
      rnd     = lfsr(rnd);
      modeVal = rnd[12:0];
      drive   = run ? rnd[13] : 1'b1;
      clrEn   = (run == 1);
      if (run == 1) begin
        rpCyc  = 4'(1 + rnd[15:14]);
        mrdCyc = 4'(1 + rnd[17:16]);
        rfcCyc = 8'(2 + rnd[20:18]);
        wb(1'b1, dpis_pkg::REG_TIM, {16'h0000, rfcCyc, mrdCyc, rpCyc});
        wb(1'b1, 8'h14, rnd);
      end
      wb(1'b0, 8'h14, 0);
      chk("unmapped", rd, 0);
      wb(1'b1, dpis_pkg::REG_MODE, 32'(modeVal));
      wb(1'b0, dpis_pkg::REG_MODE, 0);
      chk("mode readback", rd, 32'(modeVal));
      wb(1'b1, dpis_pkg::REG_CTRL, 32'({clrEn, drive, 1'b1}));
      wb(1'b0, dpis_pkg::REG_CTRL, 0);
      chk("control readback", rd, 32'({clrEn, drive, 1'b0}));
      // Whole init sequence, judged step by step by the model
      waitSig(1'b0, 1'b1, 4600, "init done");
      @(negedge clk);
      chk("init steps", stepCnt, clrEn ? 7 : 6);
      waitSig(1'b1, 1'b1, 400, "read allowed");
      @(negedge clk);
      chk("lockout", 32'(lockAge >= 200), 1);
      // Cadence: exactly three refreshes in three intervals
      r0 = refCnt;
      for (int i = 0; i < 200 && refCnt == r0; i++) @(negedge clk);
      r0 = refCnt;
      repeat (3 * dpis_pkg::REF_INT_CYC) @(negedge clk);
      chk("refresh count", refCnt - r0, 3);
      @(posedge clk);
      wb(1'b0, dpis_pkg::REG_REFS, 0);
      chk("refresh register", rd[15:0], refCnt[15:0]);
      // Relock drops reads for a fresh lockout
      wb(1'b1, dpis_pkg::REG_CTRL, 32'({1'b1, clrEn, drive, 1'b0}));
      waitSig(1'b1, 1'b0, 20, "relock drop");
      waitSig(1'b1, 1'b1, 400, "relock done");
      @(negedge clk);
      chk("relock lockout", 32'(lockAge >= 200), 1);
      @(posedge clk);
      wb(1'b0, dpis_pkg::REG_STAT, 0);
      chk("status ready", rd[1:0], 2'b11);
      chk("model faults", errCnt, 0);
      $display("Run %0d finished", run);
    end
    results();
  end
endmodule
